// file: motion_io_pkg.sv
package motion_io_pkg;

	// Register port geometry.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register offsets.
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_JOG    = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_MASK   = 4'h3;
	localparam logic [3:0] OFS_STATE  = 4'h4;

	// Control register fields.
	localparam int CTRL_BASE_HOME  = 0;
	localparam int CTRL_BASE_NEXT  = 1;
	localparam int CTRL_TOGGLE_INV = 2;
	localparam int CTRL_POS_OUT0   = 3;

	// Event bits shared by the status and mask registers.
	localparam int EV_LAUNCH = 0;
	localparam int EV_HOMING = 1;
	localparam int EV_NEXT   = 2;
	localparam int EV_JOG_ON = 3;
	localparam int EV_JOG_NO = 4;
	localparam int EV_RESUME = 5;
	localparam int EV_WCLEAR = 6;
	localparam int EV_TARGET_REACHED_OUT  = 7;
	localparam int NUM_EV    = 8;

	// State register fields.
	localparam int ST_FOLLOW = 0;
	localparam int ST_RESP   = 1;
	localparam int ST_JOG    = 2;
	localparam int ST_PEND   = 3;
	localparam int ST_TOGGLE = 4;
	localparam int ST_HOME   = 5;

	// Reset values.
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] JOG_RST  = 16'h0000;
	localparam logic [7:0]  EV_RST   = 8'h00;
	localparam logic [7:0]  NO_TASK  = 8'h00;

	// Port lines from the machine controller.
	typedef struct packed {
		logic       home;
		logic       warn_clear;
		logic       next_task;
		logic       base_next;
		logic       jog;
		logic       resume;
		logic       launch;
		logic [7:0] number;
	} port_in_t;

	// Status from the motion core.
	typedef struct packed {
		logic at_target;
		logic in_window;
		logic follow_err;
		logic resp_err;
		logic task_start;
		logic seq_active;
		logic seq_first;
	} core_stat_t;

	// Commands to the motion core.
	typedef struct packed {
		logic        launch_task;
		logic        launch_home;
		logic        next_start;
		logic        jog_start;
		logic        jog_cancel;
		logic        resume;
		logic [7:0]  task_num;
		logic [15:0] jog_speed;
	} core_cmd_t;

endpackage

// file: motion_task_io_port.sv
`timescale 1ns/100ps
module motion_task_io_port
	import motion_io_pkg::*;
(
	input  wire logic                         REF_CLK,
	input  wire logic                         SYS_RST,
	input  wire logic                         CLK_EN,
	input  wire motion_io_pkg::port_in_t      PORT_IN,
	input  wire motion_io_pkg::core_stat_t    CORE_STAT,
	output motion_io_pkg::core_cmd_t          CORE_CMD,
	output logic                              HOME_SWITCH_OUT,
	output logic                              TARGET_REACHED_OUT,
	output logic                              SEQUENCE_TOGGLE_OUT,
	output logic                              POSITION_COMPARE_OUT0,
	output logic                              FOLLOWING_ERROR_WARNING,
	output logic                              RESPONSE_MONITOR_WARNING,
	output logic                              IRQ,
	input  wire logic [motion_io_pkg::ADDR_W-1:0] REG_ADDR,
	input  wire logic [motion_io_pkg::DATA_W-1:0] REG_WDATA,
	input  wire logic                         REG_WR,
	input  wire logic                         REG_RD,
	output logic [motion_io_pkg::DATA_W-1:0]  REG_RDATA
);
	import motion_io_pkg::*;

	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);

	port_in_t         in_s1_r;
	port_in_t         in_s2_r;
	port_in_t         in_d_r;
	port_in_t         rise;
	port_in_t         fall;
	logic [15:0]      ctrl_r;
	logic [15:0]      jog_r;
	logic [7:0]       status_r;
	logic [7:0]       status_nxt;
	logic [7:0]       mask_r;
	logic [7:0]       events;
	logic             follow_r;
	logic             resp_r;
	logic             jog_act_r;
	logic             pend_r;
	logic             pend_nxt;
	logic             toggle_r;
	logic             target_reached_out_r;
	logic             home_r;
	logic             next_req;
	logic             next_go;
	logic             no_task;
	logic             seq_start;
	logic             wr_ctrl;
	logic             wr_jog;
	logic             wr_status;
	logic             wr_mask;
	logic [15:0]      rd_mux;
	logic [15:0]      state_word;
	core_cmd_t        cmd_nxt;

	// Returns true when a write strobe hits the given offset.
	function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs, input logic stb);
		hit = stb && (adr == ofs);
	endfunction

	// Three stages per line: two to synchronise, one to find edges.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			in_s1_r <= '0;
			in_s2_r <= '0;
			in_d_r  <= '0;
		end else if (CLK_EN) begin
			in_s1_r <= PORT_IN;
			in_s2_r <= in_s1_r;
			in_d_r  <= in_s2_r;
		end
	end

	// Edge detection on the synchronised lines.
	assign rise = port_in_t'(in_s2_r & ~in_d_r);
	assign fall = port_in_t'(~in_s2_r & in_d_r);

	// Address lines read as a binary number, zero meaning no task.
	assign no_task = (in_s2_r.number == NO_TASK);

	// Next-task requests from the expansion port or the base unit.
	assign next_req = rise.next_task || (ctrl_r[CTRL_BASE_NEXT] && rise.base_next);
	assign next_go  = (pend_r || next_req) && CORE_STAT.at_target;
	assign pend_nxt = (pend_r || next_req) && !CORE_STAT.at_target;

	// A sequenced task start drives the toggle output.
	assign seq_start = CORE_STAT.task_start && CORE_STAT.seq_active;

	// Commands issued this cycle, registered on the next edge.
	always_comb begin
		cmd_nxt             = '0;
		cmd_nxt.launch_task = rise.launch && !no_task;
		cmd_nxt.launch_home = rise.launch && no_task;
		cmd_nxt.next_start  = next_go;
		cmd_nxt.jog_start   = rise.jog;
		cmd_nxt.jog_cancel  = fall.jog && jog_act_r;
		cmd_nxt.resume      = rise.resume;
		cmd_nxt.task_num    = in_s2_r.number;
		cmd_nxt.jog_speed   = jog_r;
	end

	// Events that feed the sticky status register.
	assign events = {target_reached_out_r ? 1'b0 : CORE_STAT.in_window, rise.warn_clear, cmd_nxt.resume,
		cmd_nxt.jog_cancel, cmd_nxt.jog_start, cmd_nxt.next_start,
		cmd_nxt.launch_home, cmd_nxt.launch_task};

	// Register write decode.
	assign wr_ctrl   = hit(REG_ADDR, OFS_CTRL, REG_WR);
	assign wr_jog    = hit(REG_ADDR, OFS_JOG, REG_WR);
	assign wr_status = hit(REG_ADDR, OFS_STATUS, REG_WR);
	assign wr_mask   = hit(REG_ADDR, OFS_MASK, REG_WR);

	// Write-one-to-clear, a new event wins over the clear.
	assign status_nxt = (wr_status ? (status_r & ~REG_WDATA[7:0]) : status_r) | events;

	// Live state word for software.
	assign state_word = {10'h000, home_r, toggle_r, pend_r, jog_act_r, resp_r, follow_r};

	// Read selection, unmapped offsets read zero.
	assign rd_mux = (REG_ADDR == OFS_CTRL)   ? ctrl_r :
	                (REG_ADDR == OFS_JOG)    ? jog_r :
	                (REG_ADDR == OFS_STATUS) ? {8'h00, status_r} :
	                (REG_ADDR == OFS_MASK)   ? {8'h00, mask_r} :
	                (REG_ADDR == OFS_STATE)  ? state_word : 16'h0000;

	// Software registers and read data.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl_r    <= CTRL_RST;
			jog_r     <= JOG_RST;
			status_r  <= EV_RST;
			mask_r    <= EV_RST;
			REG_RDATA <= 16'h0000;
		end else if (CLK_EN) begin
			if (wr_ctrl) begin
				ctrl_r <= REG_WDATA;
			end
			if (wr_jog) begin
				jog_r <= REG_WDATA;
			end
			if (wr_mask) begin
				mask_r <= REG_WDATA[7:0];
			end
			status_r  <= status_nxt;
			REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
		end
	end

	// Warnings, jog state and the pending next-task request.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			follow_r  <= 1'b0;
			resp_r    <= 1'b0;
			jog_act_r <= 1'b0;
			pend_r    <= 1'b0;
		end else if (CLK_EN) begin
			follow_r  <= CORE_STAT.follow_err || (follow_r && !rise.warn_clear);
			resp_r    <= CORE_STAT.resp_err || (resp_r && !rise.warn_clear);
			jog_act_r <= rise.jog || (jog_act_r && !fall.jog);
			pend_r    <= pend_nxt;
		end
	end

	// Pin outputs and command register.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CORE_CMD <= '0;
			toggle_r <= 1'b0;
			target_reached_out_r  <= 1'b0;
			home_r   <= 1'b0;
		end else if (CLK_EN) begin
			CORE_CMD <= cmd_nxt;
			target_reached_out_r  <= CORE_STAT.in_window;
			home_r   <= in_s2_r.home && !ctrl_r[CTRL_BASE_HOME];
			if (seq_start) begin
				toggle_r <= CORE_STAT.seq_first ? 1'b0 : !toggle_r;
			end
		end
	end

	// Output pins, the toggle polarity being a configuration choice.
	assign HOME_SWITCH_OUT          = home_r;
	assign TARGET_REACHED_OUT       = target_reached_out_r;
	assign SEQUENCE_TOGGLE_OUT      = toggle_r ^ ctrl_r[CTRL_TOGGLE_INV];
	assign POSITION_COMPARE_OUT0    = ctrl_r[CTRL_POS_OUT0];
	assign FOLLOWING_ERROR_WARNING  = follow_r;
	assign RESPONSE_MONITOR_WARNING = resp_r;
	assign IRQ                      = |(status_r & mask_r);

	// Checks on the behaviour above.
	a_home_ignored: assert property ($past(CLK_EN) && ctrl_r[CTRL_BASE_HOME]
		&& $past(ctrl_r[CTRL_BASE_HOME]) |-> !home_r)
		else $error("Home switch passed while base input owns homing.");
	a_warn_clear: assert property (CLK_EN && rise.warn_clear && !CORE_STAT.follow_err && !CORE_STAT.resp_err
		|=> !follow_r && !resp_r)
		else $error("Warnings not cleared.");
	a_next_wait: assert property ($past(CLK_EN) && CORE_CMD.next_start |-> $past(CORE_STAT.at_target))
		else $error("Next task started before target reached.");
	a_next_issue: assert property (CLK_EN && rise.next_task && CORE_STAT.at_target |=> CORE_CMD.next_start)
		else $error("Next task not started at target.");
	a_base_next: assert property (CLK_EN && !ctrl_r[CTRL_BASE_NEXT] && !pend_r && !rise.next_task
		|=> !CORE_CMD.next_start)
		else $error("Disabled base input started a task.");
	a_jog_start: assert property (CLK_EN && rise.jog |=> CORE_CMD.jog_start && jog_act_r
		&& CORE_CMD.jog_speed == $past(jog_r))
		else $error("Jog start missing.");
	a_jog_cancel: assert property (CLK_EN && fall.jog && jog_act_r |=> CORE_CMD.jog_cancel && !jog_act_r)
		else $error("Jog cancel missing.");
	a_resume_pulse: assert property (CLK_EN && rise.resume |=> CORE_CMD.resume)
		else $error("Resume not issued.");
	a_launch_task: assert property (CLK_EN && rise.launch && !no_task
		|=> CORE_CMD.launch_task && CORE_CMD.task_num == $past(in_s2_r.number))
		else $error("Addressed task not launched.");
	a_launch_home: assert property (CLK_EN && rise.launch && no_task
		|=> CORE_CMD.launch_home && !CORE_CMD.launch_task)
		else $error("Homing not launched.");
	a_target_reached_out_follow: assert property (CLK_EN |=> TARGET_REACHED_OUT == $past(CORE_STAT.in_window))
		else $error("In-position output wrong.");
	a_toggle_first: assert property (CLK_EN && seq_start && CORE_STAT.seq_first |=> !toggle_r)
		else $error("Toggle not low at sequence start.");
	a_toggle_flip: assert property (CLK_EN && seq_start && !CORE_STAT.seq_first
		|=> toggle_r != $past(toggle_r))
		else $error("Toggle did not invert.");
	a_edge_once: assert property (CLK_EN && rise.jog |=> !rise.jog)
		else $error("One transition gave two edges.");

	// Further checks on warnings, the core commands, edge detection and the pin outputs.
	a_follow_set: assert property (CLK_EN && CORE_STAT.follow_err |=> FOLLOWING_ERROR_WARNING)
		else $error("Following-error warning not set.");
	a_resp_set: assert property (CLK_EN && CORE_STAT.resp_err |=> RESPONSE_MONITOR_WARNING)
		else $error("Response-monitor warning not set.");
	a_warn_hold: assert property (CLK_EN && follow_r && !rise.warn_clear |=> follow_r)
		else $error("Following-error warning lost without a clear.");
	a_home_polled: assert property (CLK_EN && !ctrl_r[CTRL_BASE_HOME]
		|=> HOME_SWITCH_OUT == $past(in_s2_r.home))
		else $error("Home switch not polled.");
	a_next_hold: assert property (CLK_EN && next_req && !CORE_STAT.at_target
		|=> pend_r && !CORE_CMD.next_start)
		else $error("Early next-task request not held.");
	a_next_release: assert property (CLK_EN && pend_r && CORE_STAT.at_target
		|=> CORE_CMD.next_start && !pend_r)
		else $error("Held next-task request not issued.");
	a_base_go: assert property (CLK_EN && ctrl_r[CTRL_BASE_NEXT] && rise.base_next && CORE_STAT.at_target
		|=> CORE_CMD.next_start)
		else $error("Enabled base input did not start a task.");
	a_jog_idle: assert property (CLK_EN && !jog_act_r |=> !CORE_CMD.jog_cancel)
		else $error("Jog cancelled while no jog ran.");
	a_resume_once: assert property (CLK_EN && !rise.resume |=> !CORE_CMD.resume)
		else $error("Resume issued without a rising edge.");
	a_launch_excl: assert property (!(CORE_CMD.launch_task && CORE_CMD.launch_home))
		else $error("Task and homing launched together.");
	a_task_number: assert property (CLK_EN |=> CORE_CMD.task_num == $past(in_s2_r.number))
		else $error("Task number not passed on in order.");
	a_toggle_hold: assert property (CLK_EN && !seq_start |=> toggle_r == $past(toggle_r))
		else $error("Toggle changed without a task start.");
	a_pos_write: assert property (CLK_EN && wr_ctrl
		|=> POSITION_COMPARE_OUT0 == $past(REG_WDATA[CTRL_POS_OUT0]))
		else $error("Position output not set by configuration.");
	a_toggle_form: assert property (CLK_EN && wr_ctrl
		|=> SEQUENCE_TOGGLE_OUT == ($past(REG_WDATA[CTRL_TOGGLE_INV]) ^ toggle_r))
		else $error("Toggle output form not set by configuration.");
	a_fall_once: assert property (CLK_EN && fall.jog |=> !fall.jog)
		else $error("One falling transition gave two edges.");

	// Checks on the sticky status bits, the read port and the clock enable.
	a_status_set: assert property (CLK_EN && (events != 8'h00)
		|=> (status_r & $past(events)) == $past(events))
		else $error("Event lost from the status register.");
	a_status_clear: assert property (CLK_EN && wr_status
		|=> (status_r & $past(REG_WDATA[7:0] & ~events)) == 8'h00)
		else $error("Status bit not cleared by a written one.");
	a_status_keep: assert property (CLK_EN && !wr_status
		|=> (status_r & $past(status_r)) == $past(status_r))
		else $error("Status bit lost without a clear.");
	a_rdata_status: assert property (CLK_EN && REG_RD && (REG_ADDR == OFS_STATUS)
		|=> REG_RDATA == {8'h00, $past(status_r)})
		else $error("Status read returned wrong data.");
	a_rdata_idle: assert property (CLK_EN && !REG_RD |=> REG_RDATA == 16'h0000)
		else $error("Read data shown without a read.");
	a_rdata_void: assert property (CLK_EN && REG_RD && (REG_ADDR > OFS_STATE) |=> REG_RDATA == 16'h0000)
		else $error("Unmapped offset read nonzero.");
	a_enable_freeze: assert property (!CLK_EN
		|=> $stable(ctrl_r) && $stable(status_r) && $stable(toggle_r) && $stable(CORE_CMD))
		else $error("State changed while the clock enable was low.");

endmodule

// file: controller_model.sv
`timescale 1ns/100ps
// Machine controller model: holds every port line as a level and changes lines just after a clock edge.
module controller_model
	import motion_io_pkg::*;
(
	input  wire logic               clk,
	output motion_io_pkg::port_in_t lines
);
	import motion_io_pkg::*;

	// Lines start low, so no false edge is seen when reset is released.
	initial lines = '0;

	// The task number is presented whole, with the first line as weight one.
	task automatic apply(input port_in_t v);
		@(posedge clk);
		lines <= v;
	endtask
endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
	import motion_io_pkg::*;
	localparam int LT = $bits(core_cmd_t) - 1;
	logic              clk;
	logic              rst;
	logic              en;
	logic              wr;
	logic              rd;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] d;
	port_in_t          pins;
	port_in_t          pin;
	core_stat_t        st;
	core_cmd_t         cmd;
	core_cmd_t         got;
	logic              home_o;
	logic              tgt_o;
	logic              tog_o;
	logic              pos_o;
	logic              few_o;
	logic              rmw_o;
	logic              irq;
	int                fail_count = 0;
	int                n_checks = 0;

	// The controller model drives the port lines; the bench plays the motion core.
	controller_model ctl (.clk(clk), .lines(pins));
	motion_task_io_port dut (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(en), .PORT_IN(pins), .CORE_STAT(st),
		.CORE_CMD(cmd), .HOME_SWITCH_OUT(home_o), .TARGET_REACHED_OUT(tgt_o), .SEQUENCE_TOGGLE_OUT(tog_o),
		.POSITION_COMPARE_OUT0(pos_o), .FOLLOWING_ERROR_WARNING(few_o), .RESPONSE_MONITOR_WARNING(rmw_o),
		.IRQ(irq), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));

	// The clock runs at 20 MHz.
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic final_report();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the read strobe.
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		v = rdata;
	endtask

	// Waits a bounded time for one command pulse; a miss ends the run.
	task automatic wait_cmd(input int b, input string nm);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			if (cmd[b] === 1'h1) begin
				got = cmd;
				return;
			end
		end
		chk(nm, 32'h0000_0000, 32'h0000_0001);
		final_report();
	endtask

	task automatic start_task(input logic first);
		@(posedge clk);
		st.task_start <= 1'h1;
		st.seq_active <= 1'h1;
		st.seq_first <= first;
		@(posedge clk);
		st.task_start <= 1'h0;
		@(negedge clk);
	endtask

	task automatic t_regs();
		rd_reg(OFS_CTRL, d);
		chk("ctrl reset", d, CTRL_RST);
		rd_reg(OFS_JOG, d);
		chk("jog reset", d, JOG_RST);
		rd_reg(4'hF, d);
		chk("unmapped", d, 16'h0000);
	endtask

	task automatic t_launch();
		wr_reg(OFS_MASK, 16'h0001);
		rd_reg(OFS_MASK, d);
		chk("mask", d, 16'h0001);
		pin.number = 8'hA5;
		pin.launch = 1'h1;
		ctl.apply(pin);
		wait_cmd(LT, "launch_task");
		chk("task_num", got.task_num, 8'hA5);
		cyc(1);
		chk("single launch", cmd[LT], 1'h0);
		chk("irq set", irq, 1'h1);
		rd_reg(OFS_STATUS, d);
		chk("status", d, 16'h0001);
		cyc(1);
		chk("rdata idle", rdata, 16'h0000);
		wr_reg(OFS_STATUS, 16'h0001);
		cyc(1);
		chk("irq clear", irq, 1'h0);
		pin.launch = 1'h0;
		ctl.apply(pin);
		cyc(4);
		pin.number = NO_TASK;
		pin.launch = 1'h1;
		ctl.apply(pin);
		wait_cmd(LT - 1, "launch_home");
		chk("home not task", got[LT], 1'h0);
		pin.launch = 1'h0;
		ctl.apply(pin);
	endtask

	task automatic t_next();
		int early;
		early = 0;
		pin.next_task = 1'h1;
		ctl.apply(pin);
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			early += int'(cmd[LT - 2] === 1'h1);
		end
		chk("early next", early, 0);
		@(posedge clk);
		st.at_target <= 1'h1;
		wait_cmd(LT - 2, "next_start");
		pin.next_task = 1'h0;
		pin.base_next = 1'h1;
		ctl.apply(pin);
		early = 0;
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			early += int'(cmd[LT - 2] === 1'h1);
		end
		chk("base next refused", early, 0);
		pin.base_next = 1'h0;
		ctl.apply(pin);
		wr_reg(OFS_CTRL, 16'h0002);
		pin.base_next = 1'h1;
		ctl.apply(pin);
		wait_cmd(LT - 2, "base next_start");
		pin.base_next = 1'h0;
		ctl.apply(pin);
		wr_reg(OFS_CTRL, 16'h0000);
	endtask

	task automatic t_jog_resume();
		wr_reg(OFS_JOG, 16'h1234);
		pin.jog = 1'h1;
		ctl.apply(pin);
		wait_cmd(LT - 3, "jog_start");
		chk("jog_speed", got.jog_speed, 16'h1234);
		pin.jog = 1'h0;
		ctl.apply(pin);
		wait_cmd(LT - 4, "jog_cancel");
		pin.resume = 1'h1;
		ctl.apply(pin);
		wait_cmd(LT - 5, "resume");
		pin.resume = 1'h0;
		ctl.apply(pin);
	endtask

	task automatic t_levels();
		@(posedge clk);
		st.follow_err <= 1'h1;
		st.resp_err <= 1'h1;
		st.in_window <= 1'h1;
		@(posedge clk);
		st.follow_err <= 1'h0;
		st.resp_err <= 1'h0;
		pin.home = 1'h1;
		pin.warn_clear = 1'h1;
		cyc(1);
		chk("follow warn", few_o, 1'h1);
		chk("resp warn", rmw_o, 1'h1);
		chk("in position", tgt_o, 1'h1);
		ctl.apply(pin);
		cyc(5);
		chk("follow cleared", few_o, 1'h0);
		chk("resp cleared", rmw_o, 1'h0);
		chk("home polled", home_o, 1'h1);
		wr_reg(OFS_CTRL, 16'h0009);
		st.in_window <= 1'h0;
		cyc(2);
		chk("home ignored", home_o, 1'h0);
		chk("pos out", pos_o, 1'h1);
		chk("out of position", tgt_o, 1'h0);
		wr_reg(OFS_CTRL, 16'h0000);
		rd_reg(OFS_STATE, d);
		chk("state word", d, 16'h0001 << ST_HOME);
	endtask

	task automatic t_toggle();
		start_task(1'h0);
		chk("toggle 1", tog_o, 1'h1);
		start_task(1'h0);
		chk("toggle 2", tog_o, 1'h0);
		start_task(1'h0);
		start_task(1'h1);
		chk("first task low", tog_o, 1'h0);
		wr_reg(OFS_CTRL, 16'h0004);
		cyc(1);
		chk("toggle inverted", tog_o, 1'h1);
	endtask

	// Clock enable low: a register write and a task start are both refused.
	task automatic t_freeze();
		@(posedge clk);
		en <= 1'h0;
		wr_reg(OFS_CTRL, 16'h0008);
		start_task(1'h0);
		chk("frozen write", pos_o, 1'h0);
		chk("frozen toggle", tog_o, 1'h1);
		@(posedge clk);
		en <= 1'h1;
		start_task(1'h0);
		chk("toggle after freeze", tog_o, 1'h0);
	endtask

	// Main sequence: reset for two cycles, then one task per scenario.
	initial begin
		rst = 1'h1;
		en = 1'h1;
		wr = 1'h0;
		rd = 1'h0;
		addr = '0;
		wdata = '0;
		st = '0;
		pin = '0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_launch();
		t_next();
		t_jog_resume();
		t_levels();
		t_toggle();
		t_freeze();
		final_report();
	end
endmodule
